//--- hw/rsfp_port.v
// Purpose: serial input and readback port of a single-channel rheostat
// Assumes: MCLK 125 MHz; SCLK high and low each last at least three MCLK periods
// Notes: SCLK edges are found by oversampling; serial output is open drain
`include "rsfp_defs.vh"

// What this block does
// - sample data input on SCLK falling edges
// - strobe falling edge enables bit acceptance
// - sixteen-bit shift register fed only by input
// - strobe rise after full frame applies word
// - short frame aborted, registers unchanged
// - serial output shifts out register bits
// - serial output only pulls low or releases
// - word: two zero, four command, ten data
// - frames counted in multiples of sixteen bits
// - wiper read returns value next frame end
module rsfp_port #(
  parameter WIPER_W = 10
) (
  input  wire               MCLK,
  input  wire               NRST,
  input  wire               SCLK,
  input  wire               SYNC_N,
  input  wire               DIN,
  output reg                SERIAL_OUT_OPEN_DRAIN,
  output reg                SERIAL_OUT_OPEN_DRAIN_OE,
  output reg  [WIPER_W-1:0] WIPER_REGISTER,
  output reg                WIPER_UPDATE,
  output reg                FRAME_ABORT
);
  localparam ST_IDLE = 3'b001;
  localparam ST_SHFT = 3'b010;
  localparam ST_DONE = 3'b100;

  reg [2:0]               sclk_s_q;
  reg [2:0]               sync_s_q;
  reg [2:0]               din_s_q;
  reg [2:0]               st_q;
  reg [`RSFP_CNT_W-1:0]   cnt_q;
  reg                     full_q;
  reg [`RSFP_FRAME_BITS-1:0] sh_q;
  reg [WIPER_W-1:0]       rd_q;
  reg                     rd_pend_q;
  reg                     rd_act_q;
  reg                     push_q;
  reg [`RSFP_FRAME_BITS-1:0] push_word_q;
  wire                    sclk_fall;
  wire                    sclk_rise;
  wire                    sync_fall;
  wire                    sync_rise;
  wire                    sync_low;
  wire                    din_v;
  wire                    buf_ready;
  wire                    word_valid;
  wire [`RSFP_FRAME_BITS-1:0] word;
  wire [3:0]              cmd;
  reg                     out_bit;

  // two flops on every pin, third flop used only for edge detect
  always @(posedge MCLK)
  begin
    if (!NRST)
    begin
      sclk_s_q <= 3'h0;
      sync_s_q <= 3'h7;
      din_s_q  <= 3'h0;
    end
    else
    begin
      sclk_s_q <= {sclk_s_q[1:0], SCLK};
      sync_s_q <= {sync_s_q[1:0], SYNC_N};
      din_s_q  <= {din_s_q[1:0], DIN};
    end
  end

  assign sclk_fall = sclk_s_q[2] & ~sclk_s_q[1];
  assign sclk_rise = ~sclk_s_q[2] & sclk_s_q[1];
  assign sync_fall = sync_s_q[2] & ~sync_s_q[1];
  assign sync_rise = ~sync_s_q[2] & sync_s_q[1];
  assign sync_low  = ~sync_s_q[1];
  assign din_v     = din_s_q[1];

  // frame state: idle until strobe falls, shift until it rises
  always @(posedge MCLK)
  begin
    if (!NRST)
    begin
      st_q        <= ST_IDLE;
      cnt_q       <= `RSFP_CNT_ZERO;
      full_q      <= 1'b0;
      sh_q        <= `RSFP_WORD_ZERO;
      push_q      <= 1'b0;
      push_word_q <= `RSFP_WORD_ZERO;
      FRAME_ABORT <= 1'b0;
    end
    else
    begin
      push_q      <= push_q & ~buf_ready; // hold the word until the buffer takes it
      FRAME_ABORT <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          cnt_q  <= `RSFP_CNT_ZERO;
          full_q <= 1'b0;
          if (sync_fall)
            st_q <= ST_SHFT;
        end
        ST_SHFT:
        begin
          if (sync_rise)
          begin
            st_q <= ST_DONE;
          end
          else if (sclk_fall && sync_low)
          begin
            sh_q  <= {sh_q[`RSFP_FRAME_BITS-2:0], din_v};
            cnt_q <= cnt_q + `RSFP_CNT_ONE;
            full_q <= (cnt_q == `RSFP_CNT_LAST);
          end
        end
        ST_DONE:
        begin
          st_q <= ST_IDLE;
          if (full_q && cnt_q == `RSFP_CNT_ZERO)
          begin
            push_q      <= 1'b1;
            push_word_q <= sh_q;
          end
          else
            FRAME_ABORT <= 1'b1;
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  rsfp_buf2 #(
    .WIDTH (`RSFP_FRAME_BITS)
  ) u_buf (
    .clk       (MCLK),
    .rst_n     (NRST),
    .in_valid  (push_q),
    .in_ready  (buf_ready),
    .in_data   (push_word_q),
    .out_valid (word_valid),
    .out_ready (1'b1),
    .out_data  (word)
  );

  assign cmd = word[`RSFP_CMD_HI:`RSFP_CMD_LO];

  // decode applied words
  always @(posedge MCLK)
  begin
    if (!NRST)
    begin
      WIPER_REGISTER <= `RSFP_WIPER_RESET;
      WIPER_UPDATE   <= 1'b0;
      rd_pend_q      <= 1'b0;
    end
    else
    begin
      WIPER_UPDATE <= 1'b0;
      if (word_valid)
      begin
        rd_pend_q <= (cmd == `RSFP_CMD_READ);
        if (cmd == `RSFP_CMD_WRITE)
        begin
          WIPER_REGISTER <= word[`RSFP_DATA_HI:0];
          WIPER_UPDATE   <= 1'b1;
        end
      end
    end
  end

  // readback: the frame after a read sends wiper value in its last ten bits
  always @(posedge MCLK)
  begin
    if (!NRST)
    begin
      rd_act_q <= 1'b0;
      rd_q     <= {WIPER_W{1'b0}};
    end
    else if (st_q == ST_IDLE && sync_fall)
    begin
      rd_act_q <= rd_pend_q;
      rd_q     <= WIPER_REGISTER;
    end
    else if (rd_act_q && st_q == ST_SHFT && sclk_rise &&
             cnt_q > `RSFP_READ_FIRST)
      rd_q <= {rd_q[WIPER_W-2:0], 1'b0};
  end

  always @*
  begin
    if (rd_act_q && cnt_q >= `RSFP_READ_FIRST)
      out_bit = rd_q[WIPER_W-1];
    else
      out_bit = sh_q[`RSFP_FRAME_BITS-1];
  end

  // open drain: drive low only, release while strobe high
  always @(posedge MCLK)
  begin
    if (!NRST)
    begin
      SERIAL_OUT_OPEN_DRAIN    <= 1'b0;
      SERIAL_OUT_OPEN_DRAIN_OE <= 1'b0;
    end
    else
    begin
      SERIAL_OUT_OPEN_DRAIN    <= 1'b0;
      SERIAL_OUT_OPEN_DRAIN_OE <= (st_q == ST_SHFT) && sync_low && !out_bit;
    end
  end
endmodule

//--- hw/rsfp_defs.vh
// Purpose: constants for the rheostat serial frame port
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef RSFP_DEFS_VH
`define RSFP_DEFS_VH
`define RSFP_FRAME_BITS   16
`define RSFP_CNT_W        4
`define RSFP_CNT_LAST     4'hF
`define RSFP_CNT_ZERO     4'h0
`define RSFP_CNT_ONE      4'h1
`define RSFP_READ_FIRST   4'h6
`define RSFP_CMD_HI       13
`define RSFP_CMD_LO       10
`define RSFP_DATA_HI      9
`define RSFP_CMD_NOP      4'h0
`define RSFP_CMD_WRITE    4'h1
`define RSFP_CMD_READ     4'h2
`define RSFP_WIPER_RESET  10'h200
`define RSFP_WORD_ZERO    16'h0000
`endif

//--- hw/rsfp_buf2.v
// Purpose: two-entry valid/ready buffer for received frames
// Assumes: single clock, synchronous active-low reset
// Notes: in_ready stays high while a slot is free
`include "rsfp_defs.vh"
module rsfp_buf2 #(
  parameter WIDTH = 16
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:1];
  reg             wp_q;
  reg             rp_q;
  reg [1:0]       cnt_q;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wp_q] <= in_data;
        wp_q        <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
      if (push & ~pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule

//--- verification/rsfp_chk_checker.sv
// Purpose: port checks for the rheostat frame port
// Assumes: host spaces frames by at least 400 ns
// Notes: bound to rsfp_port below
module rsfp_chk #(
  parameter WIPER_W = 10
) (
  input logic               MCLK,
  input logic               NRST,
  input logic               SCLK,
  input logic               SYNC_N,
  input logic               DIN,
  input logic               SERIAL_OUT_OPEN_DRAIN,
  input logic               SERIAL_OUT_OPEN_DRAIN_OE,
  input logic [WIPER_W-1:0] WIPER_REGISTER,
  input logic               WIPER_UPDATE,
  input logic               FRAME_ABORT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] s_q;
  logic [5:0] n_q;
  // serial clock falls seen inside the frame
  always @(posedge MCLK)
  begin
    s_q <= {s_q[0], SCLK};
    if (!NRST || $fell(SYNC_N))
      n_q <= 6'h00;
    else if (!SYNC_N && s_q[1] && !s_q[0])
      n_q <= n_q + 6'h01;
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
  sequence bad_end;
    $rose(SYNC_N) && (n_q[3:0] != 4'h0 || n_q == 6'h00);
  endsequence
  sequence good_end;
    $rose(SYNC_N) && n_q[3:0] == 4'h0 && n_q != 6'h00;
  endsequence
  od_low_a: assert property (SERIAL_OUT_OPEN_DRAIN == 1'b0)
    else $error("serial out drove high");
  idle_free_a: assert property (SYNC_N [*6] |-> !SERIAL_OUT_OPEN_DRAIN_OE)
    else $error("line held while idle");
  frame_quiet_a: assert property (!SYNC_N |-> !WIPER_UPDATE && !FRAME_ABORT)
    else $error("pulse inside frame");
  update_late_a: assert property (WIPER_UPDATE |-> SYNC_N && $past(SYNC_N, 5))
    else $error("update before frame end");
  abort_late_a: assert property (FRAME_ABORT |-> SYNC_N && $past(SYNC_N, 3))
    else $error("abort before frame end");
  wiper_cause_a: assert property ($changed(WIPER_REGISTER) |-> WIPER_UPDATE || $past(WIPER_UPDATE))
    else $error("wiper moved without update");
  pulse_single_a: assert property (WIPER_UPDATE || FRAME_ABORT |=> !WIPER_UPDATE && !FRAME_ABORT)
    else $error("pulse longer than one cycle");
  short_frame_a: assert property (bad_end |-> ##[2:10] FRAME_ABORT)
    else $error("short frame not aborted");
  full_frame_a: assert property (good_end |-> !FRAME_ABORT [*8])
    else $error("whole frame aborted");
endmodule
bind rsfp_port rsfp_chk #(.WIPER_W(WIPER_W)) chk (.MCLK(MCLK), .NRST(NRST), .SCLK(SCLK),
  .SYNC_N(SYNC_N), .DIN(DIN), .SERIAL_OUT_OPEN_DRAIN(SERIAL_OUT_OPEN_DRAIN),
  .SERIAL_OUT_OPEN_DRAIN_OE(SERIAL_OUT_OPEN_DRAIN_OE),
  .WIPER_REGISTER(WIPER_REGISTER), .WIPER_UPDATE(WIPER_UPDATE), .FRAME_ABORT(FRAME_ABORT));

//--- verification/rsfp_host.sv
// Purpose: host controller model for the frame port
// Assumes: serial clock 80 ns, idle low, still between frames
// Notes: samples the pulled-up line at each serial clock fall
module rsfp_host (
  input  logic        MCLK,
  input  logic        od_line,
  output logic        SCLK,
  output logic        SYNC_N,
  output logic        DIN,
  output logic [31:0] rx
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    SCLK = 1'b0;
    SYNC_N = 1'b1;
    DIN = 1'b0;
    rx = 32'h0000_0000;
  end
  task automatic frame(input logic [31:0] w, input int n);
    int i;
    begin
      SYNC_N <= 1'b0;
      repeat (5) @(posedge MCLK);
      for (i = n - 1; i >= 0; i--)
      begin
        SCLK <= 1'b1;
        DIN <= w[i];
        repeat (5) @(posedge MCLK);
        SCLK <= 1'b0;
        rx <= {rx[30:0], od_line};
        repeat (5) @(posedge MCLK);
      end
      SYNC_N <= 1'b1;
      DIN <= ~DIN;
      repeat (60) @(posedge MCLK);
    end
  endtask
endmodule

//--- verification/test_rheostat_serial_frame_port.sv
// Purpose: self-checking bench for the rheostat frame port
// Assumes: host model drives every frame
// Notes: pulses are counted as they pass
module test_rheostat_serial_frame_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic        MCLK;
  logic        NRST;
  wire         SCLK, SYNC_N, DIN, SERIAL_OUT_OPEN_DRAIN, SERIAL_OUT_OPEN_DRAIN_OE;
  wire         WIPER_UPDATE, FRAME_ABORT;
  wire  [9:0]  WIPER_REGISTER;
  wire  [31:0] host_rx;
  // released line is pulled up
  wire         od_line = SERIAL_OUT_OPEN_DRAIN_OE ? SERIAL_OUT_OPEN_DRAIN : 1'b1;
  int          bad_count = 0;
  int          n_checks = 0;
  int          n_upd = 0;
  int          n_abt = 0;
  rsfp_port dut (.MCLK(MCLK), .NRST(NRST), .SCLK(SCLK), .SYNC_N(SYNC_N), .DIN(DIN),
    .SERIAL_OUT_OPEN_DRAIN(SERIAL_OUT_OPEN_DRAIN),
    .SERIAL_OUT_OPEN_DRAIN_OE(SERIAL_OUT_OPEN_DRAIN_OE), .WIPER_REGISTER(WIPER_REGISTER),
    .WIPER_UPDATE(WIPER_UPDATE), .FRAME_ABORT(FRAME_ABORT));
  rsfp_host host (.MCLK(MCLK), .od_line(od_line), .SCLK(SCLK), .SYNC_N(SYNC_N),
    .DIN(DIN), .rx(host_rx));
  always @(posedge MCLK)
  begin
    n_upd <= n_upd + int'(WIPER_UPDATE === 1'b1);
    n_abt <= n_abt + int'(FRAME_ABORT === 1'b1);
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    begin
      n_checks++;
      if (seen !== exp)
      begin
        bad_count++;
        $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task automatic frm(input logic [31:0] w, input int n, input int du, input int da,
                     input logic [9:0] wv);
    int u;
    int a;
    begin
      u = n_upd;
      a = n_abt;
      host.frame(w, n);
      check("updates", 16'(n_upd - u), 16'(du));
      check("aborts", 16'(n_abt - a), 16'(da));
      check("wiper", WIPER_REGISTER, wv);
    end
  endtask
  task automatic stop_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task automatic t_reset;
    begin
      check("reset wiper", WIPER_REGISTER, 16'h0200);
      check("reset oe", SERIAL_OUT_OPEN_DRAIN_OE, 16'h0000);
      $display("reset test done");
    end
  endtask
  task automatic t_write;
    begin
      frm(32'h0000_0555, 16, 1, 0, 10'h155);
      frm(32'h0400_06A5, 32, 1, 0, 10'h2A5);
      $display("write test done");
    end
  endtask
  task automatic t_abort;
    begin
      frm(32'h0000_0155, 15, 0, 1, 10'h2A5);
      frm(32'h0001_0AAA, 17, 0, 1, 10'h2A5);
      frm(32'h0000_0000, 0, 0, 1, 10'h2A5);
      frm(32'h0000_0C12, 16, 0, 0, 10'h2A5);
      $display("abort test done");
    end
  endtask
  task automatic t_readback;
    begin
      frm(32'h0000_0800, 16, 0, 0, 10'h2A5);
      frm(32'h0000_0000, 16, 0, 0, 10'h2A5);
      check("readback", host_rx[9:0], 16'h02A5);
      check("chain", host_rx[15:10], 16'h0002);
      $display("readback test done");
    end
  endtask
  task automatic t_rearm;
    begin
      NRST <= 1'b0;
      repeat (4) @(posedge MCLK);
      NRST <= 1'b1;
      repeat (4) @(posedge MCLK);
      check("rearm wiper", WIPER_REGISTER, 16'h0200);
      frm(32'h0000_0555, 16, 1, 0, 10'h155);
      $display("rearm test done");
    end
  endtask
  initial
  begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end
  initial
  begin
    NRST = 1'b0;
    repeat (20) @(posedge MCLK);
    NRST <= 1'b1;
    repeat (4) @(posedge MCLK);
    t_reset;
    t_write;
    t_abort;
    t_readback;
    t_rearm;
    stop_test;
  end
  initial
  begin
    #100us;
    bad_count++;
    stop_test;
  end
endmodule
